//--- test/smsp_far_slave.sv
/* Far-end slave model for master transfers, MSB first in any clock mode.
   Assumes the bench pulses load with the reply byte before each byte. */
`timescale 1ns/1ns
module smsp_far_slave (
   // Serial pins
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // Bench side
   input wire logic cpol,
   input wire logic cpha,
   input wire logic load,
   input wire logic [7:0] tx,
   output logic [7:0] rx
);
   int cnt = 0;
   // The first reply bit waits on the line before the first edge.
   always @(posedge load) begin
      cnt = 0;
      miso = tx[7];
   end
   // Mode picks the capture edge; once spent, the line inverts so stale data shows.
   always @(sck) begin
      if (sck ^ cpol ^ cpha) begin
         rx = {rx[6:0], mosi};
         cnt++;
      end else begin
         miso = (cnt < 8) ? tx[7 - cnt] : ~miso;
      end
   end
endmodule

//--- test/smsp_port_properties.sv
/* Checker for the serial port top: master start, idle clock, flags and interrupt.
   Assumes it is bound to every smsp_port instance and sees only its ports. */
`timescale 1ns/1ns
module smsp_port_checker import smsp_pkg::*; #(parameter int W = 8) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial outputs
   input wire logic sck_o,
   input wire logic sck_oe_n,
   input wire logic mosi_o,
   // CPU side
   input wire logic csr_rd,
   input wire logic dr_wr,
   input wire logic [W-1:0] dr_wdata,
   input wire logic cpu_irq_mask,
   input wire logic irq_req,
   // Status
   input wire logic [7:0] ctrl_q,
   input wire logic xfer_done_flag,
   input wire logic master_fault_flag,
   input wire logic overrun_flag,
   input wire logic write_collision_flag,
   input wire logic xfer_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic rd_seen_r;
   // Remembers a status read since the done flag rose, which unlocks data writes.
   always_ff @(posedge mclk) begin
      if (!rst_n || !xfer_done_flag) rd_seen_r <= 1'b0;
      else if (csr_rd) rd_seen_r <= 1'b1;
   end
   sequence s_off;
      !ctrl_q[CR_PORT_EN] && !ctrl_q[CR_MASTER];
   endsequence
   property p_sck_idle;
      !sck_oe_n && !xfer_busy && !$past(xfer_busy) && $stable(ctrl_q) |-> sck_o == ctrl_q[CR_CPOL];
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock left its idle level");
   property p_fault;
      $rose(master_fault_flag) |-> ##[0:1] s_off;
   endproperty
   a_fault: assert property (p_fault) else $error("fault kept the port on");
   property p_fault_hold;
      master_fault_flag ##1 master_fault_flag |-> s_off;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("enable set under fault");
   property p_write_collision_flag;
      dr_wr && xfer_busy && !xfer_done_flag |=> write_collision_flag;
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy write not flagged");
   property p_irq;
      irq_req == ((xfer_done_flag || master_fault_flag || overrun_flag)
         && ctrl_q[CR_IRQ_EN] && !cpu_irq_mask);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request wrong");
   property p_ovr;
      overrun_flag && csr_rd |=> !overrun_flag;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not cleared");
   property p_done_block;
      xfer_done_flag && !rd_seen_r && !csr_rd && dr_wr && ctrl_q[CR_MASTER] |=> !xfer_busy;
   endproperty
   a_done_block: assert property (p_done_block) else $error("locked write started");
   property p_start;
      dr_wr && ctrl_q[CR_MASTER] && ctrl_q[CR_PORT_EN] && !xfer_busy && !xfer_done_flag
         |=> xfer_busy && mosi_o == $past(dr_wdata[W-1]);
   endproperty
   a_start: assert property (p_start) else $error("master did not start");
endmodule
bind smsp_port smsp_port_checker #(.W(W)) u_chk (.mclk, .rst_n, .sck_o, .sck_oe_n,
   .mosi_o, .csr_rd, .dr_wr, .dr_wdata, .cpu_irq_mask, .irq_req, .ctrl_q,
   .xfer_done_flag, .master_fault_flag, .overrun_flag, .write_collision_flag, .xfer_busy);

//--- test/smsp_port_tb.sv
/* Bench for smsp_port: master bytes at five rates in all modes, flags, fault
   and a slave byte. Assumes the package, link and port design compile first. */
`timescale 1ns/1ns
module smsp_port_tb import smsp_pkg::*; ();
   logic mclk, rst_n, sck_m, mosi_m, s_miso, s_load, ss_n_i, cpu_irq_mask;
   logic ctrl_wr, csr_wr, csr_rd, dr_wr, dr_rd, sck_i, mosi_i, miso_i;
   logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, irq_req, xfer_busy;
   logic sel_soft_mode, sel_soft_level, xfer_done_flag, master_fault_flag;
   logic overrun_flag, write_collision_flag;
   logic [1:0] csr_wdata, mode;
   logic [7:0] ctrl_wdata, dr_wdata, dr_rdata, ctrl_q, s_tx, s_rx, flg, got, cr;
   int bad_count = 0;
   int n_checks = 0;
   logic [2:0] rt [5] = '{RATE_DIV4, RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64};
   logic [7:0] hx [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
   // Pins resolve from the active-low enables.
   assign sck_i = sck_oe_n ? sck_m : sck_o;
   assign mosi_i = mosi_oe_n ? mosi_m : mosi_o;
   assign miso_i = miso_oe_n ? s_miso : miso_o;
   assign flg = {4'h0, xfer_done_flag, master_fault_flag, overrun_flag, write_collision_flag};
   smsp_port dut (.mclk, .rst_n, .sck_i, .sck_o, .sck_oe_n, .mosi_i, .mosi_o, .mosi_oe_n,
      .miso_i, .miso_o, .miso_oe_n, .ss_n_i, .ctrl_wr, .ctrl_wdata, .csr_wr, .csr_wdata,
      .csr_rd, .dr_wr, .dr_wdata, .dr_rd, .dr_rdata, .cpu_irq_mask, .irq_req, .ctrl_q,
      .sel_soft_mode, .sel_soft_level, .xfer_done_flag, .master_fault_flag, .overrun_flag,
      .write_collision_flag, .xfer_busy);
   smsp_far_slave u_far (.sck(sck_i), .mosi(mosi_i), .miso(s_miso), .cpol(mode[1]),
      .cpha(mode[0]), .load(s_load), .tx(s_tx), .rx(s_rx));
   // Free-running system clock.
   always #4 mclk = ~mclk;
   task cyc();
      @(posedge mclk);
      #1;
   endtask
   // One strobe: 0 control, 1 select, 2 data write, 3 status read, 4 data read.
   task acc(input int k, input logic [7:0] d);
      ctrl_wdata = d;
      csr_wdata = d[1:0];
      dr_wdata = d;
      {dr_rd, csr_rd, dr_wr, csr_wr, ctrl_wr} = 5'h01 << k;
      cyc();
      {dr_rd, csr_rd, dr_wr, csr_wr, ctrl_wr} = 5'h00;
      // An idle edge between strobes, so no strobe is written twice in one step.
      cyc();
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One master byte with a colliding write right behind it.
   task go(input logic [7:0] d, input logic [7:0] s, input logic [7:0] h);
      time t;
      s_tx = s;
      s_load = 1'b1;
      cyc();
      s_load = 1'b0;
      acc(2, d);
      acc(2, 8'hFF);
      @(sck_o);
      t = $time;
      @(sck_o);
      chk(8'(($time - t) / 8), h);
      for (int n = 0; n < 900 && xfer_busy !== 1'b0; n++) cyc();
      repeat (4) cyc();
      chk(s_rx, d);
   endtask
   // Bench acts as link master in phase one, select held low throughout.
   task lxfer(input logic [7:0] d, output logic [7:0] g);
      int b;
      #3;
      for (b = 7; b >= 0; b--) begin
         sck_m = 1'b1;
         mosi_m = d[b];
         #62;
         g[b] = miso_o;
         sck_m = 1'b0;
         #63;
      end
      mosi_m = ~mosi_m;
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cuts a hang short; the tests need well under a tenth of this span.
   initial begin
      #400000;
      bad_count++;
      give_verdict();
   end
   initial begin
      {mclk, sck_m, mosi_m, s_load, cpu_irq_mask, ss_n_i, rst_n} = 7'h00;
      {ctrl_wr, csr_wr, csr_rd, dr_wr, dr_rd} = 5'h00;
      {ctrl_wdata, dr_wdata, s_tx, csr_wdata, mode} = 28'h0;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      chk(flg, 8'h00);
      chk(ctrl_q, CTRL_RST);
      chk({5'h00, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
      cyc();
      cyc();
      acc(1, 8'h03);
      for (int i = 0; i < 5; i++) begin
         mode = 2'(i);
         cr = {2'b10, rt[i][2], 1'b1, mode, rt[i][1:0]};
         acc(0, cr);
         acc(0, cr | 8'h40);
         cyc();
         chk(ctrl_q, cr | 8'h40);
         chk({7'h00, sck_o}, {7'h00, mode[1]});
         go(8'hA5 ^ 8'(i), 8'h3C + 8'(i), hx[i]);
         chk(flg, 8'h09);
         chk({7'h00, irq_req}, 8'h01);
         chk(dr_rdata, 8'h3C + 8'(i));
         acc(3, 8'h00);
         acc(4, 8'h00);
         cyc();
         chk(flg, 8'h00);
      end
      go(8'h81, 8'hC3, hx[4]);
      acc(2, 8'h55);
      cyc();
      chk({7'h00, xfer_busy}, 8'h00);
      acc(3, 8'h00);
      go(8'h18, 8'h7E, hx[4]);
      chk(flg, 8'h0B);
      chk(dr_rdata, 8'hC3);
      acc(3, 8'h00);
      cyc();
      chk(flg, 8'h09);
      acc(4, 8'h00);
      acc(1, 8'h02);
      repeat (4) cyc();
      chk(flg, 8'h04);
      chk(ctrl_q, 8'h82);
      chk({7'h00, irq_req}, 8'h01);
      cpu_irq_mask = 1'b1;
      cyc();
      chk({7'h00, irq_req}, 8'h00);
      cpu_irq_mask = 1'b0;
      acc(1, 8'h03);
      acc(0, 8'hD0);
      cyc();
      chk(ctrl_q, 8'h80);
      acc(3, 8'h00);
      acc(0, 8'hD0);
      cyc();
      chk(flg, 8'h00);
      chk(ctrl_q, 8'hD0);
      acc(0, 8'h44);
      acc(1, 8'h00);
      acc(2, 8'h96);
      lxfer(8'h5A, got);
      repeat (6) cyc();
      chk(got, 8'h96);
      chk(dr_rdata, 8'h5A);
      chk(flg, 8'h08);
      acc(3, 8'h00);
      acc(2, 8'h00);
      cyc();
      chk(flg, 8'h00);
      acc(0, 8'h40);
      acc(2, 8'h11);
      cyc();
      chk(flg, 8'h01);
      give_verdict();
   end
endmodule

//--- verilog/smsp_link_if.sv
/*
 * Carrier between the port core (mclk) and the slave shifter (SCK domain).
 * Assumes tx_byte is held still by the core while a slave byte is in flight.
 */
`timescale 1ns/1ns
interface smsp_link_if #(parameter int W = 8);
   logic [W-1:0] tx_byte;
   logic [W-1:0] rx_byte;
   logic done_tgl;
   logic busy;
   logic mosi;
   logic miso;
   modport core (output tx_byte, input rx_byte, input done_tgl, input busy,
      output mosi, input miso);
   modport shift (input tx_byte, output rx_byte, output done_tgl, output busy,
      input mosi, output miso);
endinterface

//--- verilog/smsp_pkg.sv
/*
 * Shared constants for the byte-wide serial port: control field positions,
 * select control fields, clock rate codes and their half-period counts.
 * Assumes the control byte layout below is used by smsp_port, its checker and its bench.
 */
package smsp_pkg;
   // Control byte field positions.
   localparam int CR_IRQ_EN = 7;
   localparam int CR_PORT_EN = 6;
   localparam int CR_RATE2 = 5;
   localparam int CR_MASTER = 4;
   localparam int CR_CPOL = 3;
   localparam int CR_CPHA = 2;
   localparam int CR_RATE1 = 1;
   localparam int CR_RATE0 = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Select control fields of the control/status write.
   localparam int CS_SOFT_MODE = 1;
   localparam int CS_SOFT_LEVEL = 0;
   // Rate codes and mclk cycles per SCK half period.
   localparam logic [2:0] RATE_DIV4 = 3'h4;
   localparam logic [2:0] RATE_DIV8 = 3'h0;
   localparam logic [2:0] RATE_DIV16 = 3'h1;
   localparam logic [2:0] RATE_DIV32 = 3'h6;
   localparam logic [2:0] RATE_DIV64 = 3'h2;
   localparam logic [7:0] HALF_DIV4 = 8'h02;
   localparam logic [7:0] HALF_DIV8 = 8'h04;
   localparam logic [7:0] HALF_DIV16 = 8'h08;
   localparam logic [7:0] HALF_DIV32 = 8'h10;
   localparam logic [7:0] HALF_DIV64 = 8'h20;
   // Codes without a listed rate get a 64-cycle half period, twice that of the slowest divider.
   localparam logic [7:0] HALF_OTHER = 8'h40;
   // Master shift engine states.
   typedef enum logic [0:0] {SMSP_IDLE, SMSP_RUN} smsp_state_t;

   // Maps a rate code to its half-period count.
   function automatic logic [7:0] smsp_half(input logic [2:0] code);
      logic [7:0] h;
      h = HALF_OTHER;
      case (code)
         RATE_DIV4: h = HALF_DIV4;
         RATE_DIV8: h = HALF_DIV8;
         RATE_DIV16: h = HALF_DIV16;
         RATE_DIV32: h = HALF_DIV32;
         RATE_DIV64: h = HALF_DIV64;
         default: h = HALF_OTHER;
      endcase
      return h;
   endfunction
endpackage

//--- verilog/smsp_port.sv
/*
 * Byte-wide serial port, master or slave, with software or pin select,
 * four clock modes, and done, fault, overrun and collision flags.
 * Assumes the CPU presents one-cycle access strobes on mclk and that the
 * serial pins are resolved outside from the active-low output enables.
 */
`timescale 1ns/1ns
module smsp_port import smsp_pkg::*; #(parameter int W = 8) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n,
   input wire logic ss_n_i,
   // Control register write
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   // Control/status access
   input wire logic csr_wr,
   input wire logic [1:0] csr_wdata,
   input wire logic csr_rd,
   // Data register access
   input wire logic dr_wr,
   input wire logic [W-1:0] dr_wdata,
   input wire logic dr_rd,
   output logic [W-1:0] dr_rdata,
   // Interrupt
   input wire logic cpu_irq_mask,
   output logic irq_req,
   // Configuration and status
   output logic [7:0] ctrl_q,
   output logic sel_soft_mode,
   output logic sel_soft_level,
   output logic xfer_done_flag,
   output logic master_fault_flag,
   output logic overrun_flag,
   output logic write_collision_flag,
   output logic xfer_busy
);
   localparam int EW = $clog2(2 * W);
   localparam logic [EW-1:0] LAST_EDGE = EW'(2 * W - 1);

   smsp_link_if #(.W(W)) lk ();

   // Configuration, synchronisers and flag state.
   logic [7:0] ctrl_r, ctrl_nxt;
   logic soft_mode_r, soft_level_r;
   logic [1:0] ss_sync_r, miso_sync_r, tgl_sync_r, sbusy_sync_r;
   logic tgl_prev_r, done_r, done_arm_r, csr_seen_r, master_fault_flag_r, master_fault_flag_arm_r;
   logic ovr_r, write_collision_flag_r, write_collision_flag_arm_r;
   logic [W-1:0] tx_byte_r, rx_buf_r;
   // Master engine state.
   smsp_state_t state_r;
   logic [7:0] half_cnt_r;
   logic [EW-1:0] edge_cnt_r;
   logic [W-1:0] sh_r;
   logic rx_bit_r, cap_r, sck_lvl_r, m_done_r;
   // Combinational terms.
   logic port_en, master, cpol, cpha, ss_int_s, ss_int_raw, busy, slv_done;
   logic done_ev, done_clr, dr_wr_ok, load, write_collision_flag_ev, fault_ev, master_fault_flag_clr;
   logic tick, lead, lclk, lclr, lrst;
   logic [2:0] rate_code;

   generate
      if (W < 2 || (W & (W - 1)) != 0) begin : g_bad_w
         $error("smsp_port: W must be a power of two, at least 2");
      end
   endgenerate

   assign port_en = ctrl_r[CR_PORT_EN];
   assign master = ctrl_r[CR_MASTER];
   assign cpol = ctrl_r[CR_CPOL];
   assign cpha = ctrl_r[CR_CPHA];

   // Pin-side inputs pass two flip-flops before any mclk logic sees them.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ss_sync_r <= 2'h3;
         miso_sync_r <= 2'h0;
         tgl_sync_r <= 2'h0;
         sbusy_sync_r <= 2'h0;
         tgl_prev_r <= 1'b0;
      end else begin
         ss_sync_r <= {ss_sync_r[0], ss_n_i};
         miso_sync_r <= {miso_sync_r[0], miso_i};
         tgl_sync_r <= {tgl_sync_r[0], lk.done_tgl};
         sbusy_sync_r <= {sbusy_sync_r[0], lk.busy};
         tgl_prev_r <= tgl_sync_r[1];
      end
   end

   // Internal select, in each domain.
   assign ss_int_s = soft_mode_r ? soft_level_r : ss_sync_r[1];
   assign ss_int_raw = soft_mode_r ? soft_level_r : ss_n_i;

   // Slave domain: SCK folded so that rising lclk is always the capture edge.
   assign lclk = sck_i ^ cpol ^ cpha;
   assign lclr = ~rst_n | ss_int_raw | ~port_en | master;
   assign lrst = ~rst_n;
   assign lk.tx_byte = tx_byte_r;
   assign lk.mosi = mosi_i;

   smsp_slave_shift #(.W(W)) u_slave (
      .lclk(lclk),
      .lclr(lclr),
      .lrst(lrst),
      .lk(lk)
   );

   // A phase-zero slave counts as busy for as long as it is selected.
   assign slv_done = (tgl_sync_r[1] ^ tgl_prev_r) & ~master & port_en;
   assign busy = (state_r == SMSP_RUN) | (~master & port_en &
      (cpha ? sbusy_sync_r[1] : ~ss_int_s));
   assign done_ev = m_done_r | slv_done;

   // Data write acceptance: refused while done is pending until a status read, dropped if busy.
   assign dr_wr_ok = dr_wr & (~done_r | csr_seen_r);
   assign write_collision_flag_ev = dr_wr_ok & busy;
   assign load = dr_wr_ok & ~busy;
   assign done_clr = done_arm_r & (dr_rd | (dr_wr & ~master));

   // Mode fault: select seen low while master.
   assign fault_ev = master & ~ss_int_s;
   assign master_fault_flag_clr = master_fault_flag_arm_r & ctrl_wr;

   // Control next value; a fault wins over a write in the same cycle.
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ctrl_wr) begin
         ctrl_nxt = ctrl_wdata;
         if (master_fault_flag_r & ~master_fault_flag_arm_r) begin
            ctrl_nxt[CR_PORT_EN] = 1'b0;
            ctrl_nxt[CR_MASTER] = 1'b0;
         end
      end
      if (fault_ev) begin
         ctrl_nxt[CR_PORT_EN] = 1'b0;
         ctrl_nxt[CR_MASTER] = 1'b0;
      end
   end

   // Control and select configuration registers.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         soft_mode_r <= 1'b0;
         soft_level_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         if (csr_wr) begin
            soft_mode_r <= csr_wdata[CS_SOFT_MODE];
            soft_level_r <= csr_wdata[CS_SOFT_LEVEL];
         end
      end
   end

   // Done flag and its clearing sequence; a new byte end wins over a clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         done_r <= 1'b0;
         done_arm_r <= 1'b0;
         csr_seen_r <= 1'b0;
      end else begin
         done_r <= done_ev | (done_r & ~done_clr);
         if (done_ev | done_clr) begin
            done_arm_r <= 1'b0;
            csr_seen_r <= 1'b0;
         end else if (done_r) begin
            done_arm_r <= done_arm_r | csr_rd | csr_wr;
            csr_seen_r <= csr_seen_r | csr_rd;
         end
      end
   end

   // Overrun keeps the first byte since the last clear; later ones are lost.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovr_r <= 1'b0;
         rx_buf_r <= '0;
      end else begin
         ovr_r <= (done_ev & done_r & ~done_clr) | (ovr_r & ~csr_rd);
         if (done_ev & ~(done_r & ~done_clr)) begin
            rx_buf_r <= master ? sh_r : lk.rx_byte;
         end
      end
   end

   // Mode fault flag; read of status while set arms the clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         master_fault_flag_r <= 1'b0;
         master_fault_flag_arm_r <= 1'b0;
      end else begin
         master_fault_flag_r <= fault_ev | (master_fault_flag_r & ~master_fault_flag_clr);
         if (fault_ev | master_fault_flag_clr) begin
            master_fault_flag_arm_r <= 1'b0;
         end else if (master_fault_flag_r & csr_rd) begin
            master_fault_flag_arm_r <= 1'b1;
         end
      end
   end

   // Collision flag: status read while set, then a data access, clears it.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         write_collision_flag_r <= 1'b0;
         write_collision_flag_arm_r <= 1'b0;
      end else begin
         write_collision_flag_r <= write_collision_flag_ev | (write_collision_flag_r & ~(write_collision_flag_arm_r & (dr_rd | dr_wr)));
         if (write_collision_flag_ev | (write_collision_flag_arm_r & (dr_rd | dr_wr))) begin
            write_collision_flag_arm_r <= 1'b0;
         end else if (write_collision_flag_r & csr_rd) begin
            write_collision_flag_arm_r <= 1'b1;
         end
      end
   end

   // Slave preload byte; held still while the slave shifter may read it.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_byte_r <= '0;
      end else if (load) begin
         tx_byte_r <= dr_wdata;
      end
   end

   // Master engine timing terms; the rate bits are not contiguous in the control byte.
   assign rate_code = {ctrl_r[CR_RATE2], ctrl_r[CR_RATE1], ctrl_r[CR_RATE0]};
   assign tick = (state_r == SMSP_RUN) &&
      (half_cnt_r == smsp_half(rate_code) - 8'h01);
   assign lead = ~edge_cnt_r[0];

   // Master engine: 2*W SCK edges; capture on lead xor phase, shift otherwise.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= SMSP_IDLE;
         half_cnt_r <= 8'h00;
         edge_cnt_r <= '0;
         sh_r <= '0;
         rx_bit_r <= 1'b0;
         sck_lvl_r <= 1'b0;
         m_done_r <= 1'b0;
         cap_r <= 1'b0;
      end else begin
         m_done_r <= 1'b0;
         unique case (state_r)
            SMSP_IDLE: begin
               sck_lvl_r <= 1'b0;
               if (load & master & port_en) begin
                  sh_r <= dr_wdata;
                  half_cnt_r <= 8'h00;
                  edge_cnt_r <= '0;
                  state_r <= SMSP_RUN;
               end
            end
            SMSP_RUN: begin
               cap_r <= 1'b0;
               if (~master | ~port_en) begin
                  state_r <= SMSP_IDLE;
               end else if (cap_r) begin
                  // MISO is read one cycle after the capture edge, so the two
                  // synchroniser stages hold the new bit even at the fastest rate.
                  half_cnt_r <= half_cnt_r + 8'h01;
                  if (edge_cnt_r == '0) begin
                     sh_r <= {sh_r[W-2:0], miso_sync_r[1]};
                     m_done_r <= 1'b1;
                     state_r <= SMSP_IDLE;
                  end else begin
                     rx_bit_r <= miso_sync_r[1];
                  end
               end else if (tick) begin
                  half_cnt_r <= 8'h00;
                  sck_lvl_r <= ~sck_lvl_r;
                  edge_cnt_r <= edge_cnt_r + 1'b1;
                  if (lead ^ cpha) begin
                     cap_r <= 1'b1;
                  end else if (edge_cnt_r != '0) begin
                     sh_r <= {sh_r[W-2:0], rx_bit_r};
                  end
                  // Phase one ends on a capture edge and finishes in the delayed capture.
                  if (edge_cnt_r == LAST_EDGE && !cpha) begin
                     m_done_r <= 1'b1;
                     state_r <= SMSP_IDLE;
                  end
               end else begin
                  half_cnt_r <= half_cnt_r + 8'h01;
               end
            end
         endcase
      end
   end

   // Pins: SCK and MOSI driven as master, MISO driven as selected slave.
   assign sck_o = cpol ^ sck_lvl_r;
   assign mosi_o = sh_r[W-1];
   assign miso_o = lk.miso;
   assign sck_oe_n = ~(port_en & master);
   assign mosi_oe_n = ~(port_en & master);
   assign miso_oe_n = ~(port_en & ~master & ~ss_int_raw);

   // Shared interrupt line for done, fault and overrun; collision never asks.
   assign irq_req = ctrl_r[CR_IRQ_EN] & ~cpu_irq_mask & (done_r | master_fault_flag_r | ovr_r);

   // Status outputs.
   assign dr_rdata = rx_buf_r;
   assign ctrl_q = ctrl_r;
   assign sel_soft_mode = soft_mode_r;
   assign sel_soft_level = soft_level_r;
   assign xfer_done_flag = done_r;
   assign master_fault_flag = master_fault_flag_r;
   assign overrun_flag = ovr_r;
   assign write_collision_flag = write_collision_flag_r;
   assign xfer_busy = busy;
endmodule

//--- verilog/smsp_slave_shift.sv
/*
 * Slave shifter clocked by the incoming serial clock with polarity and
 * phase folded in, so data is always captured on the rising edge of lclk.
 * Assumes lclr is high whenever the slave is not selected or not enabled.
 */
`timescale 1ns/1ns
module smsp_slave_shift #(parameter int W = 8) (
   // Link clock and clears
   input wire logic lclk,
   input wire logic lclr,
   input wire logic lrst,
   // Core side
   smsp_link_if.shift lk
);
   localparam int CW = $clog2(W);

   logic [CW-1:0] bit_cnt_r;
   logic [W-1:0] rx_sh_r;
   logic out_bit_r;
   logic done_tgl_r;
   logic [W-1:0] rx_byte_r;

   generate
      if (W < 2 || (W & (W - 1)) != 0) begin : g_bad_w
         $error("smsp_slave_shift: W must be a power of two, at least 2");
      end
   endgenerate

   // Capture edge: incoming bits enter at the bottom, first bit ends on top.
   always_ff @(posedge lclk or posedge lclr) begin
      if (lclr) begin
         bit_cnt_r <= '0;
         rx_sh_r <= '0;
      end else begin
         rx_sh_r <= {rx_sh_r[W-2:0], lk.mosi};
         bit_cnt_r <= bit_cnt_r + 1'b1;
      end
   end

   // Byte end: the toggle survives the select clear so no event is lost.
   always_ff @(posedge lclk or posedge lrst) begin
      if (lrst) begin
         done_tgl_r <= 1'b0;
         rx_byte_r <= '0;
      end else if (bit_cnt_r == CW'(W - 1)) begin
         done_tgl_r <= ~done_tgl_r;
         rx_byte_r <= {rx_sh_r[W-2:0], lk.mosi};
      end
   end

   // Launch edge: the next bit, counted from the top, goes out.
   always_ff @(negedge lclk or posedge lclr) begin
      if (lclr) begin
         out_bit_r <= 1'b0;
      end else begin
         out_bit_r <= lk.tx_byte[CW'(W - 1) - bit_cnt_r];
      end
   end

   // The top bit is presented before any edge, as phase zero needs.
   assign lk.miso = (bit_cnt_r == '0) ? lk.tx_byte[W-1] : out_bit_r;
   assign lk.busy = (bit_cnt_r != '0);
   assign lk.rx_byte = rx_byte_r;
   assign lk.done_tgl = done_tgl_r;
endmodule
